// ==== common/rwt_pkg.sv ====
// Constants and state types for the ready-window bus target
package rwt_pkg;

    // Bus addressing and special byte values
    localparam logic [6:0] DEV_ADDR = 7'h56;
    localparam logic [7:0] REG_SETUP = 8'h80;
    localparam logic [7:0] REG_TIMEOUT = 8'h83;
    localparam logic [7:0] CMD_END = 8'hFF;
    localparam logic [7:0] FILLER = 8'hEE;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] PTR_STEP = 8'h01;

    // Register fields and reset values
    localparam int STOP_DIS_BIT = 5;
    localparam logic [15:0] SETUP_RST = 16'h0000;
    localparam logic [15:0] TIMEOUT_RST = 16'h000A;

    // Millisecond tick derived from the system clock rate
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 5;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
    localparam int SUB_W = 18;
    localparam logic [15:0] MS_STEP = 16'h0001;

    // Window events: power mode, halt or activation, auto_tuning,
    // in-wear auto_tuning error, wear state change
    localparam int NUM_EVENTS = 5;

    // Pin and toggle positions
    localparam int PIN_SDA = 0;
    localparam int PIN_SCL = 1;
    localparam int T_CLOSE = 0;
    localparam int T_SVC = 1;
    localparam int T_FORCE = 2;
    localparam int T_CFG = 3;
    localparam int NUM_TGL = 4;

    typedef enum logic [2:0] {
        L_IDLE,
        L_ADDR,
        L_ADDR_ACK,
        L_RX,
        L_RX_ACK,
        L_TX,
        L_TX_ACK
    } rwt_phase_type;

    typedef struct packed {
        logic scl_q;
        logic sda_q;
        rwt_phase_type phase;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic sel;
        logic hi;
        logic have_ptr;
        logic acked;
        logic [7:0] ptr;
        logic [7:0] wlo;
        logic [15:0] setup;
        logic [15:0] tmo;
        logic sda_oe;
        logic sda_o;
        logic [NUM_TGL-1:0] tgl;
    } rwt_link_state_type;

    typedef struct packed {
        logic win;
        logic served;
        logic ev_pend;
        logic force_pend;
        logic rdy_o;
        logic [NUM_TGL-1:0] tgl_q;
        logic [15:0] tmo;
        logic [15:0] ms;
        logic [SUB_W-1:0] sub;
    } rwt_sys_state_type;

endpackage : rwt_pkg

// ==== design/rwt_sync.sv ====
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module rwt_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import rwt_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rwt_sync_state_type;

    rwt_sync_state_type st_ff;
    rwt_sync_state_type nxt_st;

    // First stage feeds only the second stage
    always_comb begin
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.s2;

endmodule : rwt_sync

// ==== design/rwt_ready_window_target.sv ====
// Two-wire bus target with open-drain ready window line
`timescale 1ns/1ps

// Notes on behaviour
// R1: Two-wire target plus separate ready line
// R2: Ready open-drain, low only in window
// R3: Answer to seven-bit address 0x56
// R4: Byte address, two data bytes each
// R5: Low byte first, then high byte
// R6: Reads advance address after both bytes
// R7: Writes single or burst, step two bytes
// R8: Unserviced window closes after timeout
// R9: Timeout in ms, default 10, reg 0x83
// R10: Bus STOP closes window by default
// R11: Stop-disable bit 5; 0xFF ends window
// R12: Unknown register reads return 0xEE
// R13: Reads outside window return 0xEE
// R14: Streaming opens window every report interval
// R15: Event mode opens only on enabled events
// R16: Five events each separately enabled
// R17: Forced request opens window within interval
// R18: Host forces request before event-mode access
// R19: Host retries off-interval, then master_clear_pin
// R20: Host avoids forcing while ready low
// R21: Stretching and slow acknowledge tolerated
// R22: Host uses ready line as interrupt
module rwt_ready_window_target #(
    parameter int MS_CYCLES = rwt_pkg::MS_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic rdy_o,
    output logic rdy_oe,
    input wire logic event_mode,
    input wire logic [rwt_pkg::NUM_EVENTS-1:0] event_in,
    input wire logic [rwt_pkg::NUM_EVENTS-1:0] event_en,
    input wire logic report_tick
);
    import rwt_pkg::*;

    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(MS_CYCLES - 1);
    localparam logic [SUB_W-1:0] SUB_STEP = SUB_W'(1);

    rwt_link_state_type l_ff, nxt_l;
    rwt_sys_state_type s_ff, nxt_s;

    logic lrst_n, win_s, scl_s, sda_s;
    logic [1:0] pin_s;
    logic [NUM_TGL-1:0] tgl_s, edges;
    logic rise, fall, start, stop;
    logic [7:0] tx_byte;
    logic ev_hit, open_now;

    ////////////////////////////////////////////////////////////////////
    // Crossings

    // Link-side reset follows the system reset, released on link_clk
    rwt_sync #(.W(1)) u_rst_sync (
        .clk(link_clk), .rst_n(1'b1), .d(resetn), .q(lrst_n)
    );
    // Bus pins are asynchronous to the link sampling clock; left unreset
    // so idle-high pins never show a false edge after reset
    rwt_sync #(.W(2)) u_pin_sync (
        .clk(link_clk), .rst_n(1'b1), .d({scl_i, sda_i}), .q(pin_s)
    );
    rwt_sync #(.W(1)) u_win_sync (
        .clk(link_clk), .rst_n(lrst_n), .d(s_ff.win), .q(win_s)
    );
    // Events from the link travel as toggles
    rwt_sync #(.W(NUM_TGL)) u_tgl_sync (
        .clk(clk), .rst_n(resetn), .d(l_ff.tgl), .q(tgl_s)
    );

    ////////////////////////////////////////////////////////////////////
    // Link domain: bus bit engine and register file

    assign scl_s = pin_s[PIN_SCL];
    assign sda_s = pin_s[PIN_SDA];

    always_comb begin
        nxt_l = l_ff;
        nxt_l.scl_q = scl_s;
        nxt_l.sda_q = sda_s;
        rise = scl_s & ~l_ff.scl_q;
        fall = ~scl_s & l_ff.scl_q;
        start = scl_s & l_ff.scl_q & l_ff.sda_q & ~sda_s;
        stop = scl_s & l_ff.scl_q & ~l_ff.sda_q & sda_s;
        // Only two registers live here; all else reads as filler
        if (!win_s) begin
            tx_byte = FILLER; // R13
        end else if (l_ff.ptr == REG_SETUP) begin
            tx_byte = l_ff.hi ? l_ff.setup[15:8] : l_ff.setup[7:0]; // R5
        end else if (l_ff.ptr == REG_TIMEOUT) begin
            tx_byte = l_ff.hi ? l_ff.tmo[15:8] : l_ff.tmo[7:0]; // R5
        end else begin
            tx_byte = FILLER; // R12
        end
        if (start) begin
            nxt_l.phase = L_ADDR;
            nxt_l.cnt = '0;
            nxt_l.sda_oe = 1'b0;
        end else if (stop) begin
            // Stop-disable leaves only the end command, or the timeout of an unserved window, to close it
            if (l_ff.sel && !l_ff.setup[STOP_DIS_BIT]) begin
                nxt_l.tgl[T_CLOSE] = ~l_ff.tgl[T_CLOSE]; // R10 R11
            end
            nxt_l.phase = L_IDLE;
            nxt_l.sel = 1'b0;
            nxt_l.sda_oe = 1'b0;
        end else begin
            unique case (l_ff.phase)
                L_IDLE: begin
                end
                L_ADDR: begin
                    if (rise) begin
                        nxt_l.sh = {l_ff.sh[6:0], sda_s};
                        nxt_l.cnt = l_ff.cnt + 4'h1;
                    end else if (fall && l_ff.cnt == BYTE_BITS) begin
                        if (l_ff.sh[7:1] == DEV_ADDR) begin // R3
                            nxt_l.sda_oe = 1'b1;
                            nxt_l.rw = l_ff.sh[0];
                            nxt_l.sel = 1'b1;
                            nxt_l.phase = L_ADDR_ACK;
                            if (!l_ff.sh[0]) begin
                                nxt_l.have_ptr = 1'b0;
                            end
                            // Address hit while closed is a forced request
                            if (win_s) begin
                                nxt_l.tgl[T_SVC] = ~l_ff.tgl[T_SVC];
                            end else begin
                                nxt_l.tgl[T_FORCE] = ~l_ff.tgl[T_FORCE]; // R17
                            end
                        end else begin
                            nxt_l.phase = L_IDLE;
                        end
                    end
                end
                L_ADDR_ACK, L_RX_ACK: begin
                    // Never stretches the clock; data is ready at once
                    if (fall) begin // R21
                        nxt_l.cnt = '0;
                        if (l_ff.rw) begin
                            nxt_l.sh = tx_byte;
                            nxt_l.sda_oe = ~tx_byte[7];
                            nxt_l.phase = L_TX;
                        end else begin
                            nxt_l.sda_oe = 1'b0;
                            nxt_l.phase = L_RX;
                        end
                    end
                end
                L_RX: begin
                    if (rise) begin
                        nxt_l.sh = {l_ff.sh[6:0], sda_s};
                        nxt_l.cnt = l_ff.cnt + 4'h1;
                    end else if (fall && l_ff.cnt == BYTE_BITS) begin
                        nxt_l.sda_oe = 1'b1;
                        nxt_l.phase = L_RX_ACK;
                        if (!l_ff.have_ptr) begin
                            if (l_ff.sh == CMD_END) begin
                                nxt_l.tgl[T_CLOSE] = ~l_ff.tgl[T_CLOSE]; // R11
                            end else begin
                                nxt_l.ptr = l_ff.sh; // R4
                                nxt_l.have_ptr = 1'b1;
                                nxt_l.hi = 1'b0;
                            end
                        end else if (!l_ff.hi) begin
                            nxt_l.wlo = l_ff.sh; // R5
                            nxt_l.hi = 1'b1;
                        end else begin
                            // Word complete: store and step on for bursts
                            nxt_l.hi = 1'b0;
                            nxt_l.ptr = l_ff.ptr + PTR_STEP; // R7
                            if (win_s && l_ff.ptr == REG_SETUP) begin
                                nxt_l.setup = {l_ff.sh, l_ff.wlo}; // R11
                            end
                            if (win_s && l_ff.ptr == REG_TIMEOUT) begin
                                nxt_l.tmo = {l_ff.sh, l_ff.wlo}; // R9
                                nxt_l.tgl[T_CFG] = ~l_ff.tgl[T_CFG];
                            end
                        end
                    end
                end
                L_TX: begin
                    if (rise) begin
                        nxt_l.cnt = l_ff.cnt + 4'h1;
                    end else if (fall && l_ff.cnt == BYTE_BITS) begin
                        nxt_l.sda_oe = 1'b0;
                        nxt_l.phase = L_TX_ACK;
                        if (l_ff.hi) begin
                            nxt_l.hi = 1'b0;
                            nxt_l.ptr = l_ff.ptr + PTR_STEP; // R6
                        end else begin
                            nxt_l.hi = 1'b1; // R4
                        end
                    end else if (fall) begin
                        nxt_l.sh = {l_ff.sh[6:0], 1'b0};
                        nxt_l.sda_oe = ~l_ff.sh[6];
                    end
                end
                L_TX_ACK: begin
                    if (rise) begin
                        nxt_l.acked = ~sda_s;
                    end else if (fall) begin
                        // A not-acknowledge ends the read
                        if (l_ff.acked) begin
                            nxt_l.sh = tx_byte;
                            nxt_l.sda_oe = ~tx_byte[7];
                            nxt_l.cnt = '0;
                            nxt_l.phase = L_TX;
                        end else begin
                            nxt_l.phase = L_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            l_ff <= '0;
            l_ff.scl_q <= 1'b1;
            l_ff.sda_q <= 1'b1;
            l_ff.setup <= SETUP_RST;
            l_ff.tmo <= TIMEOUT_RST; // R9
        end else begin
            l_ff <= nxt_l;
        end
    end

    // Open-drain data: only ever pulled low
    assign sda_o = l_ff.sda_o;
    assign sda_oe = l_ff.sda_oe; // R1

    ////////////////////////////////////////////////////////////////////
    // System domain: window control

    always_comb begin
        nxt_s = s_ff;
        edges = tgl_s ^ s_ff.tgl_q;
        nxt_s.tgl_q = tgl_s;
        ev_hit = |(event_in & event_en); // R16
        if (event_mode) begin
            open_now = s_ff.ev_pend || ev_hit
                || (s_ff.force_pend && report_tick); // R15 R17
        end else begin
            open_now = report_tick; // R14
        end
        // Timeout value is stable once its toggle has crossed
        if (edges[T_CFG]) begin
            nxt_s.tmo = l_ff.tmo; // R9
        end
        if (!s_ff.win) begin
            if (open_now) begin
                nxt_s.win = 1'b1;
                nxt_s.served = 1'b0;
                nxt_s.ms = '0;
                nxt_s.sub = '0;
                nxt_s.ev_pend = 1'b0;
                nxt_s.force_pend = 1'b0;
            end
        end else if (edges[T_CLOSE]) begin
            nxt_s.win = 1'b0; // R10 R11
        end else if (edges[T_SVC]) begin
            nxt_s.served = 1'b1;
        end else if (!s_ff.served) begin
            if (s_ff.ms >= s_ff.tmo) begin
                nxt_s.win = 1'b0; // R8
            end else if (s_ff.sub == SUB_LAST) begin
                nxt_s.sub = '0;
                nxt_s.ms = s_ff.ms + MS_STEP; // R9
            end else begin
                nxt_s.sub = s_ff.sub + SUB_STEP;
            end
        end
        // Late events are kept: a set wins over the clear above
        if (edges[T_FORCE] && !s_ff.win) begin
            nxt_s.force_pend = 1'b1; // R17
        end
        if (event_mode && ev_hit && s_ff.win) begin
            nxt_s.ev_pend = 1'b1; // R15
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_ff <= '0;
            s_ff.tmo <= TIMEOUT_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Ready is pulled low exactly while the window is open
    assign rdy_o = s_ff.rdy_o;
    assign rdy_oe = s_ff.win; // R2

    ////////////////////////////////////////////////////////////////////
    // Checks on the system domain

    a_stream_opens: assert property ( // R14
        @(posedge clk) disable iff (!resetn)
        !s_ff.win && !event_mode && report_tick |=> rdy_oe
    ) else $error("stream window did not open on report tick");
    a_event_opens: assert property ( // R15 R16
        @(posedge clk) disable iff (!resetn)
        !s_ff.win && event_mode && |(event_in & event_en) |=> rdy_oe
    ) else $error("enabled event did not open window");
    a_event_quiet: assert property ( // R15
        @(posedge clk) disable iff (!resetn)
        !s_ff.win && event_mode && !(|(event_in & event_en))
        && !s_ff.ev_pend && !s_ff.force_pend |=> !rdy_oe
    ) else $error("window opened in event mode without cause");
    a_force_opens: assert property ( // R17
        @(posedge clk) disable iff (!resetn)
        !s_ff.win && s_ff.force_pend && report_tick |=> rdy_oe
    ) else $error("forced request not honoured at report tick");
    a_close_window: assert property ( // R10 R11
        @(posedge clk) disable iff (!resetn)
        s_ff.win && edges[T_CLOSE] |=> !rdy_oe ##1 !rdy_oe
            || $past(event_mode)
    ) else $error("close request left window open");
    a_timeout_close: assert property ( // R8 R9
        @(posedge clk) disable iff (!resetn)
        s_ff.win && !s_ff.served && !edges[T_SVC] && !edges[T_CLOSE]
        && s_ff.sub == SUB_LAST && s_ff.ms == s_ff.tmo - MS_STEP
        |=> rdy_oe ##1 !rdy_oe
    ) else $error("window timeout not taken on time");

    ////////////////////////////////////////////////////////////////////
    // Checks on the link domain

    a_addr_ack: assert property ( // R3
        @(posedge link_clk) disable iff (!lrst_n)
        !start && !stop && l_ff.phase == L_ADDR && fall
        && l_ff.cnt == BYTE_BITS && l_ff.sh[7:1] == DEV_ADDR
        |=> sda_oe && l_ff.sel
    ) else $error("own address not acknowledged");
    a_addr_nack: assert property ( // R3
        @(posedge link_clk) disable iff (!lrst_n)
        !start && !stop && l_ff.phase == L_ADDR && fall
        && l_ff.cnt == BYTE_BITS && l_ff.sh[7:1] != DEV_ADDR
        |=> !sda_oe && l_ff.phase == L_IDLE
    ) else $error("foreign address acknowledged");
    a_filler_closed: assert property ( // R13
        @(posedge link_clk) disable iff (!lrst_n)
        !start && !stop && l_ff.phase == L_TX_ACK && fall
        && l_ff.acked && !win_s |=> l_ff.sh == FILLER
    ) else $error("closed-window read not answered with filler");
    a_ptr_step: assert property ( // R6
        @(posedge link_clk) disable iff (!lrst_n)
        !start && !stop && l_ff.phase == L_TX && fall
        && l_ff.cnt == BYTE_BITS && l_ff.hi
        |=> l_ff.ptr == $past(l_ff.ptr) + PTR_STEP && !l_ff.hi
    ) else $error("read pointer did not advance after high byte");
    a_stop_close: assert property ( // R10 R11
        @(posedge link_clk) disable iff (!lrst_n)
        stop && l_ff.sel
        |=> l_ff.tgl[T_CLOSE] != $past(l_ff.tgl[T_CLOSE])
            == !$past(l_ff.setup[STOP_DIS_BIT])
    ) else $error("stop handling ignores stop-disable setting");

endmodule : rwt_ready_window_target

// ==== tb/rwt_host_model.sv ====
// Host bus controller model driving clock and data of the two-wire bus
`timescale 1ns/1ps
module rwt_host_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic hp(input int n);
        repeat (n) @(posedge clk);
    endtask : hp

    // Data moves only a quarter phase after clock low, away from the syncs
    task automatic pulse(output logic s);
        hp(10);
        scl <= 1'b1;
        hp(20);
        s = sda_line;
        scl <= 1'b0;
        hp(10);
    endtask : pulse

    // Serves as start and as repeated start
    task automatic start();
        sda_pull <= 1'b0;
        hp(10);
        scl <= 1'b1;
        hp(20);
        sda_pull <= 1'b1;
        hp(20);
        scl <= 1'b0;
        hp(10);
    endtask : start

    task automatic stop();
        sda_pull <= 1'b1;
        hp(10);
        scl <= 1'b1;
        hp(20);
        sda_pull <= 1'b0;
        hp(20);
    endtask : stop

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sda_pull <= !b[i];
            pulse(s);
        end
        sda_pull <= 1'b0;
        pulse(s);
        ack = !s;
    endtask : wbyte

    // Line left released on entry by the previous acknowledge
    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(s);
            b[i] = s;
        end
        sda_pull <= ack;
        pulse(s);
        sda_pull <= 1'b0;
        hp(5);
    endtask : rbyte
endmodule : rwt_host_model

// ==== tb/tb.sv ====
// Self-checking bench for the ready-window bus target
`timescale 1ns/1ps
module tb;
    import rwt_pkg::*;
    localparam logic [7:0] WR = {DEV_ADDR, 1'b0};
    localparam logic [7:0] RD = {DEV_ADDR, 1'b1};
    localparam logic [15:0] FW = {FILLER, FILLER};
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic resetn = 1'b0;
    logic report_tick = 1'b0;
    logic event_mode = 1'b0;
    logic [NUM_EVENTS-1:0] event_in = '0;
    logic [NUM_EVENTS-1:0] event_en = '0;
    logic sda_o, sda_oe, rdy_o, rdy_oe, scl, sda_pull;
    wire sda_line = !(sda_oe | sda_pull);
    wire rdy_line = !rdy_oe;
    int err_total = 0;
    int num_checks = 0;

    always #2.5 clk = ~clk;
    // Link clock of 6 ns period, offset by 1.3 ns, so its edges drift against the 5 ns system clock
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    rwt_ready_window_target #(.MS_CYCLES(200)) dut (.clk(clk),
        .resetn(resetn), .link_clk(link_clk), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .rdy_o(rdy_o),
        .rdy_oe(rdy_oe), .event_mode(event_mode), .event_in(event_in),
        .event_en(event_en), .report_tick(report_tick));
    rwt_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input string nm, input logic [15:0] exp,
        input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_val

    task automatic chk_bit(input string nm, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_bit

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic wait_rdy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (rdy_oe !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk_bit("rdy_oe", lvl, rdy_oe);
        if (rdy_oe !== lvl) begin
            close_out();
        end
    endtask : wait_rdy

    task automatic tick();
        @(posedge clk);
        report_tick <= 1'b1;
        @(posedge clk);
        report_tick <= 1'b0;
        @(negedge clk);
    endtask : tick

    task automatic pulse_ev(input int i, input logic en);
        @(posedge clk);
        event_en <= en ? NUM_EVENTS'(1 << i) : '0;
        event_in <= NUM_EVENTS'(1 << i);
        @(posedge clk);
        event_in <= '0;
        @(negedge clk);
    endtask : pulse_ev

    task automatic wr(input logic [7:0] ra, input logic [15:0] d[$]);
        logic a;
        host.start();
        host.wbyte(WR, a);
        chk_bit("write addr ack", 1'b1, a);
        host.wbyte(ra, a);
        foreach (d[i]) begin
            host.wbyte(d[i][7:0], a);
            host.wbyte(d[i][15:8], a);
        end
        host.stop();
    endtask : wr

    // Without a pointer phase the read goes on from the current pointer
    task automatic rd(input logic [7:0] ra, input logic ptr,
        input logic [15:0] exp[$]);
        logic a;
        logic [7:0] lo, hi;
        if (ptr) begin
            host.start();
            host.wbyte(WR, a);
            host.wbyte(ra, a);
        end
        host.start();
        host.wbyte(RD, a);
        chk_bit("read addr ack", 1'b1, a);
        foreach (exp[i]) begin
            host.rbyte(1'b1, lo);
            host.rbyte(i != exp.size() - 1, hi);
            chk_val("read word", exp[i], {hi, lo});
        end
        host.stop();
    endtask : rd

    task automatic end_cmd();
        logic a;
        host.start();
        host.wbyte(WR, a);
        host.wbyte(CMD_END, a);
        host.stop();
    endtask : end_cmd

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic a;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk_bit("rdy_oe", 1'b0, rdy_oe);
        chk_bit("sda_oe", 1'b0, sda_oe);
        chk_bit("sda_o", 1'b0, sda_o);
        chk_bit("rdy_o", 1'b0, rdy_o);
        repeat (8) @(posedge clk);
        rd(8'h00, 1'b0, '{FW});
        $display("test closed_read finished");
        tick();
        wait_rdy(1'b1, 4);
        chk_bit("rdy_line", 1'b0, rdy_line);
        host.start();
        host.wbyte(8'hAE, a);
        host.stop();
        chk_bit("foreign addr ack", 1'b0, a);
        rd(REG_SETUP, 1'b1, '{SETUP_RST, FW, FW, TIMEOUT_RST});
        wait_rdy(1'b0, 60);
        $display("test map_read finished");
        tick();
        wr(8'h82, '{16'h1234, 16'h0102});
        wait_rdy(1'b0, 60);
        tick();
        rd(8'h82, 1'b1, '{FW, 16'h0102});
        wait_rdy(1'b0, 60);
        $display("test burst_write finished");
        tick();
        wr(REG_SETUP, '{16'h0020});
        repeat (40) @(negedge clk);
        chk_bit("rdy_oe", 1'b1, rdy_oe);
        end_cmd();
        wait_rdy(1'b0, 60);
        tick();
        rd(REG_SETUP, 1'b1, '{16'h0020});
        repeat (40) @(negedge clk);
        chk_bit("rdy_oe", 1'b1, rdy_oe);
        wr(REG_SETUP, '{16'h0000});
        wait_rdy(1'b0, 60);
        $display("test stop_disable finished");
        @(posedge clk);
        event_mode <= 1'b1;
        tick();
        repeat (6) @(negedge clk);
        chk_bit("rdy_oe", 1'b0, rdy_oe);
        for (int i = 0; i < NUM_EVENTS; i++) begin
            pulse_ev(i, 1'b0);
            repeat (4) @(negedge clk);
            chk_bit("rdy_oe", 1'b0, rdy_oe);
            pulse_ev(i, 1'b1);
            wait_rdy(1'b1, 4);
            end_cmd();
            wait_rdy(1'b0, 60);
        end
        $display("test event_mode finished");
        rd(8'h00, 1'b0, '{FW});
        repeat (6) @(negedge clk);
        chk_bit("rdy_oe", 1'b0, rdy_oe);
        rd(8'h00, 1'b0, '{FW});
        tick();
        wait_rdy(1'b1, 4);
        end_cmd();
        wait_rdy(1'b0, 60);
        $display("test forced_request finished");
        @(posedge clk);
        event_mode <= 1'b0;
        tick();
        wr(REG_TIMEOUT, '{16'h0002});
        wait_rdy(1'b0, 60);
        tick();
        wait_rdy(1'b1, 4);
        repeat (150) @(negedge clk);
        chk_bit("rdy_oe", 1'b1, rdy_oe);
        wait_rdy(1'b0, 700);
        $display("test window_timeout finished");
        close_out();
    end
endmodule : tb
